// *** hw/tcs_channel.sv ***
`include "tcs_cfg.svh"
`default_nettype none

// Behaviour
// - A/B writes only taken in waveform configuration
// - A/B/C are 16-bit, upper bits read zero
// - bit 0 set on overflow, read clears
// - bit 1 flags unread reload, capture only
// - bits 2/3 match A/B, waveform only
// - bit 4 set on match with C
// - bits 5/6 loads A/B, capture only
// - bit 7 set on external trigger
// - bit 16 shows counter clock enabled now
// - bit 17 mirrors line A pin or drive
// - bit 18 mirrors line B pin or drive
// - enable register sets mask bits on ones
// - disable register clears mask bits on ones
// - mask register reads enabled sources
// - waveform-select: zero capture, one waveform
module tcs_channel
   import tcs_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_srst,
   input  wire tcs_bus_s    i_bus,
   output logic [31:0]      o_rdata,
   input  wire tcs_eng_s    i_eng,
   output logic [31:0]      o_mode,
   output logic             o_wave,
   output logic [15:0]      o_compare_a,
   output logic [15:0]      o_compare_b,
   output logic [15:0]      o_compare_c,
   output logic             o_irq
);

   logic [31:0] mode_ff;
   logic [15:0] cmp_a_ff;
   logic [15:0] cmp_b_ff;
   logic [15:0] cmp_c_ff;
   logic        unread_a_ff;
   logic        unread_b_ff;
   tcs_evt_s    status_ff;
   tcs_evt_s    mask_ff;
   logic        irq_ff;
   logic [31:0] rdata_ff;

   tcs_evt_s    nxt_status;
   tcs_evt_s    nxt_mask;
   tcs_evt_s    evt_set;
   logic [31:0] nxt_rdata;

   logic        wave;
   logic        wr_mode;
   logic        wr_a;
   logic        wr_b;
   logic        wr_c;
   logic        wr_ien;
   logic        wr_idis;
   logic        rd_a;
   logic        rd_b;
   logic        rd_status;
   logic        ld_a;
   logic        ld_b;
   logic        overrun_a;
   logic        overrun_b;
   logic        mirror_a;
   logic        mirror_b;
   logic [7:0]  keep_valid;
   logic [31:0] status_word;

   // ---------------------------------------------------------------
   // address decode
   // ---------------------------------------------------------------
   assign wr_mode   = i_bus.wr && (i_bus.addr == `TCS_OFF_MODE);
   assign wr_a      = i_bus.wr && (i_bus.addr == `TCS_OFF_CMP_A);
   assign wr_b      = i_bus.wr && (i_bus.addr == `TCS_OFF_CMP_B);
   assign wr_c      = i_bus.wr && (i_bus.addr == `TCS_OFF_CMP_C);
   assign wr_ien    = i_bus.wr && (i_bus.addr == `TCS_OFF_IRQ_SET);
   assign wr_idis   = i_bus.wr && (i_bus.addr == `TCS_OFF_IRQ_CLR);
   assign rd_a      = i_bus.rd && (i_bus.addr == `TCS_OFF_CMP_A);
   assign rd_b      = i_bus.rd && (i_bus.addr == `TCS_OFF_CMP_B);
   assign rd_status = i_bus.rd && (i_bus.addr == `TCS_OFF_STATUS);

   // ---------------------------------------------------------------
   // channel mode word; only the waveform-select bit is used here,
   // the rest is handed to the engines unchanged
   // ---------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         mode_ff <= `TCS_RST_MODE;
      end else if (wr_mode) begin
         mode_ff <= i_bus.wdata;
      end
   end

   assign wave = mode_ff[`TCS_WAVE_BIT];

   // capture loads only exist in capture configuration
   assign ld_a = !wave && i_eng.load_a;
   assign ld_b = !wave && i_eng.load_b;

   // ---------------------------------------------------------------
   // compare/capture value registers
   // ---------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         cmp_a_ff <= `TCS_RST_CMP;
      end else if (ld_a) begin
         cmp_a_ff <= i_eng.capture_value;
      end else if (wave && wr_a) begin
         cmp_a_ff <= i_bus.wdata[15:0];
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         cmp_b_ff <= `TCS_RST_CMP;
      end else if (ld_b) begin
         cmp_b_ff <= i_eng.capture_value;
      end else if (wave && wr_b) begin
         cmp_b_ff <= i_bus.wdata[15:0];
      end
   end

   // register C takes writes in both configurations
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         cmp_c_ff <= `TCS_RST_CMP;
      end else if (wr_c) begin
         cmp_c_ff <= i_bus.wdata[15:0];
      end
   end

   // ---------------------------------------------------------------
   // unread tracking for load overrun; a read in the same cycle as a
   // load returns the old value, so it consumes the previous load
   // ---------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         unread_a_ff <= 1'b0;
      end else if (ld_a) begin
         unread_a_ff <= 1'b1;
      end else if (rd_a || wave) begin
         unread_a_ff <= 1'b0;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         unread_b_ff <= 1'b0;
      end else if (ld_b) begin
         unread_b_ff <= 1'b1;
      end else if (rd_b || wave) begin
         unread_b_ff <= 1'b0;
      end
   end

   assign overrun_a = ld_a && unread_a_ff && !rd_a;
   assign overrun_b = ld_b && unread_b_ff && !rd_b;

   // ---------------------------------------------------------------
   // event sources
   // ---------------------------------------------------------------
   always_comb begin
      evt_set                   = '0;
      evt_set.overflow_flag     = i_eng.overflow;
      evt_set.load_overrun_flag = overrun_a || overrun_b;
      evt_set.match_a_flag      = wave && i_eng.match_a;
      evt_set.match_b_flag      = wave && i_eng.match_b;
      evt_set.match_c_flag      = i_eng.match_c;
      evt_set.load_a_flag       = ld_a;
      evt_set.load_b_flag       = ld_b;
      evt_set.ext_trigger_flag  = i_eng.ext_trigger;
   end

   // a mode change wipes flags that cannot exist in the new mode
   assign keep_valid = wave ? `TCS_WAVE_EVENTS : `TCS_CAPTURE_EVENTS;

   // a status read clears, but an event in the same cycle survives
   always_comb begin
      nxt_status = tcs_evt_s'(evt_set | (rd_status ? `TCS_RST_STATUS : status_ff));
      nxt_status = tcs_evt_s'(nxt_status & keep_valid);
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         status_ff <= tcs_evt_s'(`TCS_RST_STATUS);
      end else begin
         status_ff <= nxt_status;
      end
   end

   // ---------------------------------------------------------------
   // interrupt mask: enable sets, disable clears, zeros ignored
   // ---------------------------------------------------------------
   always_comb begin
      nxt_mask = mask_ff;
      if (wr_ien) begin
         nxt_mask = tcs_evt_s'(mask_ff | i_bus.wdata[7:0]);
      end
      if (wr_idis) begin
         nxt_mask = tcs_evt_s'(mask_ff & ~i_bus.wdata[7:0]);
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         mask_ff <= tcs_evt_s'(`TCS_RST_MASK);
      end else begin
         mask_ff <= nxt_mask;
      end
   end

   // registered so the line never glitches on decode
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= |(nxt_status & nxt_mask);
      end
   end

   // ---------------------------------------------------------------
   // read path
   // ---------------------------------------------------------------
   assign mirror_a = wave ? i_eng.timer_line_a_drv : i_eng.timer_line_a_pin;
   assign mirror_b = wave ? i_eng.timer_line_b_drv : i_eng.timer_line_b_pin;

   always_comb begin
      status_word                    = '0;
      status_word[7:0]               = status_ff;
      status_word[`TCS_CLK_ON_BIT]   = i_eng.counter_clock_on;
      status_word[`TCS_MIRROR_A_BIT] = mirror_a;
      status_word[`TCS_MIRROR_B_BIT] = mirror_b;
   end

   // write-only and unmapped addresses read as zero
   always_comb begin
      nxt_rdata = `TCS_RST_RDATA;
      if (i_bus.rd) begin
         unique case (i_bus.addr)
            `TCS_OFF_MODE:     nxt_rdata = mode_ff;
            `TCS_OFF_CMP_A:    nxt_rdata = {16'h0000, cmp_a_ff};
            `TCS_OFF_CMP_B:    nxt_rdata = {16'h0000, cmp_b_ff};
            `TCS_OFF_CMP_C:    nxt_rdata = {16'h0000, cmp_c_ff};
            `TCS_OFF_STATUS:   nxt_rdata = status_word;
            `TCS_OFF_IRQ_MASK: nxt_rdata = {24'h00_0000, mask_ff};
            default:           nxt_rdata = `TCS_RST_RDATA;
         endcase
      end
   end

   // data valid only in the cycle after the read strobe
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         rdata_ff <= `TCS_RST_RDATA;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign o_rdata     = rdata_ff;
   assign o_mode      = mode_ff;
   assign o_wave      = wave;
   assign o_compare_a = cmp_a_ff;
   assign o_compare_b = cmp_b_ff;
   assign o_compare_c = cmp_c_ff;
   assign o_irq       = irq_ff;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_srst);

   AST_A_WRITE_BLOCKED: assert property (
      wr_a && !wave && !i_eng.load_a |=> cmp_a_ff == $past(cmp_a_ff))
      else $error("compare A took a write in capture mode");

   AST_B_WRITE_TAKEN: assert property (
      wr_b && wave |=> cmp_b_ff == $past(i_bus.wdata[15:0]))
      else $error("compare B ignored a write in waveform mode");

   AST_C_READBACK: assert property (
      (wr_c |=> o_compare_c == $past(i_bus.wdata[15:0]))
      and (i_bus.rd && i_bus.addr == `TCS_OFF_CMP_C
           |=> o_rdata == {16'h0000, $past(cmp_c_ff)}))
      else $error("compare C write or readback wrong");

   AST_OVF_SET_CLEAR: assert property (
      (i_eng.overflow |=> status_ff.overflow_flag)
      and (rd_status && !i_eng.overflow |=> !status_ff.overflow_flag))
      else $error("overflow flag set or clear wrong");

   AST_OVERRUN_A: assert property (
      !wave && i_eng.load_a ##1 (!rd_a && !wave)
      ##1 (!rd_a && !wave && i_eng.load_a)
      |=> status_ff.load_overrun_flag)
      else $error("load overrun not flagged");

   AST_WAVE_ONLY_FLAGS: assert property (
      $past(wave) == 1'b0 && !wave
      |-> !status_ff.match_a_flag && !status_ff.match_b_flag)
      else $error("match flag set in capture mode");

   AST_CAPTURE_ONLY_FLAGS: assert property (
      $past(wave) && wave |-> !status_ff.load_overrun_flag
      && !status_ff.load_a_flag && !status_ff.load_b_flag)
      else $error("capture flag set in waveform mode");

   AST_MATCH_C: assert property (
      i_eng.match_c |=> status_ff.match_c_flag)
      else $error("match C flag not set");

   AST_TRIGGER_SURVIVES_READ: assert property (
      rd_status && i_eng.ext_trigger |=> status_ff.ext_trigger_flag)
      else $error("trigger lost against status read");

   AST_STATUS_LEVELS: assert property (
      rd_status |=> o_rdata[`TCS_CLK_ON_BIT] == $past(i_eng.counter_clock_on)
      && o_rdata[`TCS_MIRROR_A_BIT] == $past(mirror_a)
      && o_rdata[`TCS_MIRROR_B_BIT] == $past(mirror_b))
      else $error("status level bits wrong");

   AST_MASK_SET: assert property (
      wr_ien |=> (mask_ff & $past(i_bus.wdata[7:0])) == $past(i_bus.wdata[7:0]))
      else $error("enable write did not set mask bits");

   AST_MASK_CLEAR: assert property (
      wr_idis |=> (mask_ff & $past(i_bus.wdata[7:0])) == 8'h00
      && (mask_ff | $past(i_bus.wdata[7:0])) == ($past(mask_ff) | $past(i_bus.wdata[7:0])))
      else $error("disable write wrong");

   AST_MASK_READ: assert property (
      i_bus.rd && i_bus.addr == `TCS_OFF_IRQ_MASK
      |=> o_rdata == {24'h00_0000, $past(mask_ff)})
      else $error("mask readback wrong");

   AST_IRQ_LEVEL: assert property (
      o_irq == |(status_ff & mask_ff))
      else $error("interrupt does not follow masked status");

   AST_A_WRITE_TAKEN: assert property (
      wr_a && wave |=> cmp_a_ff == $past(i_bus.wdata[15:0]))
      else $error("compare A ignored a write in waveform mode");

   AST_B_WRITE_BLOCKED: assert property (
      wr_b && !wave && !i_eng.load_b |=> cmp_b_ff == $past(cmp_b_ff))
      else $error("compare B took a write in capture mode");

   AST_OVERRUN_B: assert property (
      !wave && i_eng.load_b ##1 (!rd_b && !wave)
      ##1 (!rd_b && !wave && i_eng.load_b)
      |=> status_ff.load_overrun_flag)
      else $error("load overrun on B not flagged");

   AST_MATCH_AB: assert property (
      (wave && i_eng.match_a |=> status_ff.match_a_flag)
      and (wave && i_eng.match_b |=> status_ff.match_b_flag))
      else $error("match A or B flag not set");

   AST_LOAD_A: assert property (
      !wave && i_eng.load_a
      |=> status_ff.load_a_flag && o_compare_a == $past(i_eng.capture_value))
      else $error("capture load A wrong");

   AST_LOAD_B: assert property (
      !wave && i_eng.load_b
      |=> status_ff.load_b_flag && o_compare_b == $past(i_eng.capture_value))
      else $error("capture load B wrong");

   AST_FLAGS_CLEAR: assert property (
      rd_status && !i_eng.match_c && !i_eng.ext_trigger
      |=> !status_ff.match_c_flag && !status_ff.ext_trigger_flag)
      else $error("status read left a flag set");

endmodule // tcs_channel

`default_nettype wire

// *** common/tcs_cfg.svh ***
`ifndef TCS_CFG_SVH
`define TCS_CFG_SVH

// register byte addresses
`define TCS_OFF_MODE     8'h04
`define TCS_OFF_CMP_A    8'h14
`define TCS_OFF_CMP_B    8'h18
`define TCS_OFF_CMP_C    8'h1C
`define TCS_OFF_STATUS   8'h20
`define TCS_OFF_IRQ_SET  8'h24
`define TCS_OFF_IRQ_CLR  8'h28
`define TCS_OFF_IRQ_MASK 8'h2C

// field positions
`define TCS_WAVE_BIT     15
`define TCS_CLK_ON_BIT   16
`define TCS_MIRROR_A_BIT 17
`define TCS_MIRROR_B_BIT 18

// event bits that may be set in each configuration
`define TCS_CAPTURE_EVENTS 8'hF3
`define TCS_WAVE_EVENTS    8'h9D

// reset values
`define TCS_RST_MODE     32'h0000_0000
`define TCS_RST_CMP      16'h0000
`define TCS_RST_STATUS   8'h00
`define TCS_RST_MASK     8'h00
`define TCS_RST_RDATA    32'h0000_0000

`endif

// *** common/tcs_pkg.sv ***
`default_nettype none

package tcs_pkg;

   // one word of the register port
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } tcs_bus_s;

   // event and level inputs from the counter, capture and waveform engines
   typedef struct packed {
      logic        overflow;
      logic        match_a;
      logic        match_b;
      logic        match_c;
      logic        load_a;
      logic        load_b;
      logic        ext_trigger;
      logic        counter_clock_on;
      logic        timer_line_a_pin;
      logic        timer_line_b_pin;
      logic        timer_line_a_drv;
      logic        timer_line_b_drv;
      logic [15:0] capture_value;
   } tcs_eng_s;

   // event flag layout shared by status, enable, disable and mask
   typedef struct packed {
      logic ext_trigger_flag;
      logic load_b_flag;
      logic load_a_flag;
      logic match_c_flag;
      logic match_b_flag;
      logic match_a_flag;
      logic load_overrun_flag;
      logic overflow_flag;
   } tcs_evt_s;

endpackage

`default_nettype wire

// *** test/tcs_sw_model.sv ***
`default_nettype none

// software side of the register port: one-cycle strobes, never both at once
module tcs_sw_model
   import tcs_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic [31:0] i_rdata,
   output var  tcs_bus_s    o_bus
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      o_bus = '0;
   end

   task automatic write_reg(input logic [7:0] addr, input logic [31:0] data);
      @(posedge i_clk);
      o_bus <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
      @(posedge i_clk);
      o_bus.wr <= 1'b0;
      #1;
   endtask

   // a status read acknowledges every latched flag at once
   task automatic read_reg(input logic [7:0] addr, output logic [31:0] data);
      @(posedge i_clk);
      o_bus <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 32'h0000_0000};
      @(posedge i_clk);
      o_bus.rd <= 1'b0;
      #1;
      data = i_rdata;
   endtask
endmodule // tcs_sw_model

`default_nettype wire

// *** test/tcs_channel_test.sv ***
`include "tcs_cfg.svh"
`default_nettype none

`define CHK(got, exp) \
   begin \
      n_compared++; \
      if ((got) !== (exp)) begin \
         num_errors++; \
         $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
      end \
   end

module tcs_channel_test
   import tcs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic        i_clk;
   logic        i_srst;
   tcs_bus_s    bus;
   tcs_eng_s    eng;
   logic [31:0] rdata;
   logic [31:0] mode;
   logic        wave;
   logic        irq;
   logic [15:0] cmp_a;
   logic [15:0] cmp_b;
   logic [15:0] cmp_c;
   int          num_errors;
   int          n_compared;
   int          cycles;

   tcs_channel tcs_channel_i (
      .i_clk(i_clk), .i_srst(i_srst), .i_bus(bus), .o_rdata(rdata), .i_eng(eng),
      .o_mode(mode), .o_wave(wave), .o_compare_a(cmp_a), .o_compare_b(cmp_b),
      .o_compare_c(cmp_c), .o_irq(irq));

   tcs_sw_model tcs_sw_model_i (.i_clk(i_clk), .i_rdata(rdata), .o_bus(bus));

   initial begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end

   task automatic wrap_up;
      $display("compared %0d, errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // the run needs well under 1000 cycles
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 5000) begin
         num_errors++;
         wrap_up();
      end
   end

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      tcs_sw_model_i.write_reg(a, d);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      tcs_sw_model_i.read_reg(a, d);
      `CHK(d, e)
   endtask

   // pulses in status bit layout; bit 1 has no source of its own
   task automatic ev(input logic [7:0] p);
      @(posedge i_clk);
      eng.overflow    <= p[0];
      eng.match_a     <= p[2];
      eng.match_b     <= p[3];
      eng.match_c     <= p[4];
      eng.load_a      <= p[5];
      eng.load_b      <= p[6];
      eng.ext_trigger <= p[7];
      @(posedge i_clk);
      {eng.overflow, eng.match_a, eng.match_b, eng.match_c} <= 4'h0;
      {eng.load_a, eng.load_b, eng.ext_trigger} <= 3'h0;
      #1;
   endtask

   task automatic t_regs;
      rd_chk(`TCS_OFF_STATUS, 32'h0000_0000);
      rd_chk(`TCS_OFF_IRQ_SET, 32'h0000_0000);
      rd_chk(8'h30, 32'h0000_0000);
      wr(`TCS_OFF_CMP_A, 32'hFFFF_1111);
      wr(`TCS_OFF_CMP_B, 32'hFFFF_2222);
      wr(`TCS_OFF_CMP_C, 32'hFFFF_3333);
      rd_chk(`TCS_OFF_CMP_A, 32'h0000_0000);
      rd_chk(`TCS_OFF_CMP_B, 32'h0000_0000);
      rd_chk(`TCS_OFF_CMP_C, 32'h0000_3333);
      wr(`TCS_OFF_MODE, 32'h0000_8000);
      `CHK(wave, 1'b1)
      wr(`TCS_OFF_CMP_A, 32'hFFFF_1111);
      wr(`TCS_OFF_CMP_B, 32'hFFFF_2222);
      wr(`TCS_OFF_CMP_C, 32'h0000_4444);
      rd_chk(`TCS_OFF_CMP_A, 32'h0000_1111);
      rd_chk(`TCS_OFF_CMP_B, 32'h0000_2222);
      rd_chk(`TCS_OFF_CMP_C, 32'h0000_4444);
      `CHK(cmp_b, 16'h2222)
      `CHK(cmp_a, 16'h1111)
      `CHK(cmp_c, 16'h4444)
      `CHK(mode, 32'h0000_8000)
      rd_chk(`TCS_OFF_MODE, 32'h0000_8000);
      wr(`TCS_OFF_STATUS, 32'hFFFF_FFFF);
      wr(`TCS_OFF_IRQ_MASK, 32'hFFFF_FFFF);
      rd_chk(`TCS_OFF_STATUS, 32'h0000_0000);
      rd_chk(`TCS_OFF_IRQ_MASK, 32'h0000_0000);
      wr(`TCS_OFF_MODE, 32'h0000_0000);
      `CHK(wave, 1'b0)
   endtask

   task automatic t_capture;
      ev(8'h20);
      rd_chk(`TCS_OFF_STATUS, 32'h0000_0020);
      rd_chk(`TCS_OFF_CMP_A, 32'h0000_ABCD);
      ev(8'h20);
      ev(8'h20);
      rd_chk(`TCS_OFF_STATUS, 32'h0000_0022);
      rd_chk(`TCS_OFF_STATUS, 32'h0000_0000);
      ev(8'h40);
      ev(8'h40);
      rd_chk(`TCS_OFF_STATUS, 32'h0000_0042);
      ev(8'h9D);
      rd_chk(`TCS_OFF_STATUS, 32'h0000_0091);
      rd_chk(`TCS_OFF_STATUS, 32'h0000_0000);
   endtask

   task automatic t_wave;
      wr(`TCS_OFF_MODE, 32'h0000_8000);
      ev(8'hFD);
      rd_chk(`TCS_OFF_STATUS, 32'h0000_009D);
      rd_chk(`TCS_OFF_STATUS, 32'h0000_0000);
   endtask

   // pin and driven levels differ so the mirror source is visible
   task automatic t_mirror;
      @(posedge i_clk);
      eng.counter_clock_on <= 1'b1;
      {eng.timer_line_a_drv, eng.timer_line_b_drv} <= 2'h2;
      {eng.timer_line_a_pin, eng.timer_line_b_pin} <= 2'h1;
      rd_chk(`TCS_OFF_STATUS, 32'h0003_0000);
      wr(`TCS_OFF_MODE, 32'h0000_0000);
      rd_chk(`TCS_OFF_STATUS, 32'h0005_0000);
      @(posedge i_clk);
      eng.counter_clock_on <= 1'b0;
      rd_chk(`TCS_OFF_STATUS, 32'h0004_0000);
   endtask

   task automatic t_irq;
      wr(`TCS_OFF_IRQ_SET, 32'h0000_0010);
      rd_chk(`TCS_OFF_IRQ_MASK, 32'h0000_0010);
      wr(`TCS_OFF_IRQ_SET, 32'h0000_0081);
      rd_chk(`TCS_OFF_IRQ_MASK, 32'h0000_0091);
      wr(`TCS_OFF_IRQ_CLR, 32'h0000_0001);
      wr(`TCS_OFF_IRQ_CLR, 32'h0000_0000);
      rd_chk(`TCS_OFF_IRQ_MASK, 32'h0000_0090);
      ev(8'h01);
      `CHK(irq, 1'b0)
      ev(8'h10);
      `CHK(irq, 1'b1)
      rd_chk(`TCS_OFF_STATUS, 32'h0004_0011);
      `CHK(irq, 1'b0)
      ev(8'h80);
      `CHK(irq, 1'b1)
      wr(`TCS_OFF_IRQ_CLR, 32'h0000_00FF);
      rd_chk(`TCS_OFF_IRQ_MASK, 32'h0000_0000);
      `CHK(irq, 1'b0)
      rd_chk(`TCS_OFF_STATUS, 32'h0004_0080);
   endtask

   // a trigger in the very cycle of a status read must survive the clear
   task automatic t_race;
      logic [31:0] d;
      fork
         tcs_sw_model_i.read_reg(`TCS_OFF_STATUS, d);
         begin
            @(posedge i_clk);
            eng.ext_trigger <= 1'b1;
            @(posedge i_clk);
            eng.ext_trigger <= 1'b0;
         end
      join
      `CHK(d, 32'h0004_0000)
      rd_chk(`TCS_OFF_STATUS, 32'h0004_0080);
   endtask

   initial begin
      i_srst = 1'b1;
      eng = '0;
      num_errors = 0;
      n_compared = 0;
      cycles = 0;
      repeat (10) @(posedge i_clk);
      i_srst <= 1'b0;
      eng.capture_value <= 16'hABCD;
      t_regs();
      t_capture();
      t_wave();
      t_mirror();
      t_irq();
      t_race();
      wrap_up();
   end
endmodule // tcs_channel_test

`default_nettype wire
